/* File: epcs_mc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module epcs_mc_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Requests
   input wire logic mc_req,
   input wire logic [17:0] mc_addr,
   // Answer control
   input wire logic [2:0] lat,
   input wire logic err_in,
   input wire logic uncorr_in,
   // Answers
   output logic mc_done,
   output logic mc_err,
   output logic mc_uncorr,
   output logic [15:0] mc_rdata
);
   logic [3:0] cnt_ff;
   logic [1:0] sel_ff;
   logic fin;
   assign fin = cnt_ff == 4'h1;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= 4'h0;
         sel_ff <= 2'h0;
         mc_done <= 1'b0;
         mc_err <= 1'b0;
         mc_uncorr <= 1'b0;
         mc_rdata <= 16'h0000;
      end else begin
         mc_done <= fin;
         // Sideband is only valid with done, so it keeps moving otherwise
         mc_err <= fin ? err_in : ~mc_err;
         mc_uncorr <= fin ? uncorr_in : ~mc_uncorr;
         mc_rdata <= fin ? (sel_ff == 2'h0 ? 16'h5a3c : (sel_ff == 2'h3 ? 16'hff02 : 16'h0000)) : ~mc_rdata;
         if (mc_req) begin
            cnt_ff <= {1'b0, lat} + 4'h1;
            sel_ff <= mc_addr[1:0];
         end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: epcs_pkg.sv */
`default_nettype none
package epcs_pkg;
   // Command codes carried in the first parameter slot
   localparam logic [7:0] CMD_ERASE_VERIFY_ALL = 8'h01;
   localparam logic [7:0] CMD_PROGRAM_PFLASH = 8'h06;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
   localparam logic [7:0] CMD_UNSECURE = 8'h0b;
   localparam logic [7:0] CMD_PROGRAM_EEPROM = 8'h11;
   localparam logic [7:0] CMD_ERASE_EE_SECTOR = 8'h12;
   // Parameter index values
   localparam logic [2:0] IDX_ADDR_LO = 3'h1;
   localparam logic [2:0] IDX_FIRST_WORD = 3'h2;
   localparam logic [2:0] IDX_LAST_WORD = 3'h5;
   localparam logic [2:0] IDX_NONE = 3'h0;
   // Configuration field holding the backdoor key
   localparam logic [17:0] KEY_FIRST = 18'h3ff00;
   localparam logic [17:0] KEY_LAST = 18'h3ff07;
   localparam logic [17:0] ADDR_TOP = 18'h3ffff;
   // Protection register layout
   localparam int PROT_EN_BIT = 7;
   localparam int PROT_ALL_BIT = 6;
   localparam int PROT_UNIT_SHIFT = 6;
   localparam logic [7:0] PROT_DEFAULT = 8'hc0;
   // Security field
   localparam logic [1:0] SEC_UNSECURED = 2'h2;
   localparam logic [7:0] FLASH_SECURITY_REG_DEFAULT = 8'h00;
   localparam logic [7:0] FLASH_OPTION_REG_DEFAULT = 8'hff;
   localparam logic [15:0] CFG_DEFAULT = 16'h0000;
   // Reset initialization steps
   localparam logic [1:0] INIT_STEP_CFG = 2'h0;
   localparam logic [1:0] INIT_STEP_PROGRAM_MEMORY_PROTECTION_REG = 2'h1;
   localparam logic [1:0] INIT_STEP_EEPROM_PROTECTION_REG = 2'h2;
   localparam logic [1:0] INIT_STEP_OPTSEC = 2'h3;
   localparam logic [1:0] INIT_HOLD_LAST = 2'h1;
   typedef enum logic [2:0] {
      MC_NONE, MC_LOAD, MC_PROGRAM, MC_ERASE_SECTOR, MC_ERASE_VERIFY_ALL, MC_ERASE_ALL
   } epcs_mc_op_t;
   typedef enum logic [2:0] {
      ST_INIT, ST_INIT_WAIT, ST_IDLE, ST_RUN, ST_UNSEC_VERIFY, ST_FINISH
   } epcs_state_t;
endpackage
`default_nettype wire

/* File: epcs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; $display("Error %s expected %h seen %h", what, exp, got); end end
module epcs_tb_top;
   import epcs_pkg::*;
   localparam logic [17:0] EB = 18'h00400;
   localparam logic [17:0] EN = 18'h00c00;
   localparam logic [17:0] SB = 18'h00004;
   typedef struct packed {epcs_mc_op_t o; logic [2:0] n; logic [17:0] a; logic [3:0][15:0] w;} epcs_tb_req_t;
   logic ref_clk = 1'b0, rstn = 1'b0, launch_i = 1'b0, clr = 1'b0, irq_en = 1'b0, spec = 1'b0, ewr = 1'b0;
   logic [2:0] idx = 3'h2, lat = 3'h2;
   logic [17:0] addr = 18'h00000;
   logic [3:0][15:0] words = '0;
   logic [7:0] pdata = 8'h00;
   logic fwr = 1'b0, debug_cmds_en;
   logic [7:0] code = CMD_PROGRAM_EEPROM;
   logic [2:0] bad_idx [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
   logic err_in = 1'b0, uncorr_in = 1'b0, prev_flag = 1'b0, rise_d = 1'b0;
   logic [31:0] lfsr = 32'h8576;
   logic command_complete_flag, access_error_flag, protection_violation_flag, verify_status_upper;
   logic verify_status_lower, cmd_irq, cpu_stall, flash_read_en, secured, mc_req, mc_done, mc_err, mc_uncorr;
   logic [7:0] program_memory_protection_reg, eeprom_protection_reg, flash_option_reg, flash_security_reg;
   logic [15:0] block_cfg, mc_rdata;
   epcs_mc_op_t mc_op;
   logic [17:0] mc_addr;
   logic [2:0] mc_words;
   logic [3:0][15:0] mc_wdata;
   epcs_tb_req_t req_q[$];
   epcs_tb_req_t er;
   logic [3:0] done_q[$];
   logic [3:0] en;
   int miscompares = 0;
   int checks_done = 0;
   epcs_top #(.EE_BASE(EB), .EE_BYTES(EN), .PF_BASE(18'h08000), .SECTOR_BYTES(SB)) i_epcs_top (
      .ref_clk, .rstn, .cmd_launch(launch_i), .cmd_code(code), .command_param_index(idx),
      .cmd_addr(addr), .command_param_object(words), .err_flags_clr(clr), .command_complete_irq_enable(irq_en),
      .special_mode_pin(spec), .program_memory_protection_reg_wr(fwr), .eeprom_protection_reg_wr(ewr), .prot_wdata(pdata), .command_complete_flag,
      .access_error_flag, .protection_violation_flag, .verify_status_upper, .verify_status_lower, .cmd_irq,
      .cpu_stall, .flash_read_en, .secured, .debug_cmds_en, .program_memory_protection_reg,
      .eeprom_protection_reg, .flash_option_reg, .flash_security_reg, .block_cfg, .mc_req, .mc_op, .mc_addr,
      .mc_words, .mc_wdata, .mc_done, .mc_err, .mc_uncorr, .mc_rdata);
   epcs_mc_model i_epcs_mc_model (.ref_clk, .rstn, .mc_req, .mc_addr, .lat, .err_in, .uncorr_in, .mc_done,
      .mc_err, .mc_uncorr, .mc_rdata);
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_flag();
      int n;
      n = 0;
      while (command_complete_flag !== 1'b1 && n < 200) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 200) begin
         miscompares++;
         $display("Error command_complete_flag expected 1 seen %b", command_complete_flag);
         wrap_up();
      end
   endtask
   // Note order is access error, violation, verify upper, verify lower
   task automatic launch(input logic [2:0] i, input logic [17:0] a, input logic [3:0] note);
      epcs_mc_op_t op;
      @(negedge ref_clk);
      idx = i;
      addr = a;
      for (int k = 0; k < 4; k++) begin
         lfsr = lfsr_next(lfsr);
         words[k] = lfsr[15:0];
      end
      lat = lfsr[18:16];
      irq_en = lfsr[20];
      op = MC_ERASE_VERIFY_ALL;
      if (code == CMD_PROGRAM_EEPROM) op = MC_PROGRAM;
      if (code == CMD_ERASE_EE_SECTOR) op = MC_ERASE_SECTOR;
      if (note[3:2] == 2'b00) begin
         // Unsecure erases everything, then checks it blank
         if (code == CMD_UNSECURE) req_q.push_back('{MC_ERASE_ALL, 3'h0, a, words});
         req_q.push_back('{op, i - 3'h1, (code == CMD_ERASE_EE_SECTOR) ? a & ~(SB - 18'h1) : a, words});
      end
      done_q.push_back(note);
      launch_i = 1'b1;
      @(negedge ref_clk);
      launch_i = 1'b0;
      wait_flag();
      clr = note[3:2] != 2'b00;
      repeat (3) @(negedge ref_clk);
      clr = 1'b0;
   endtask
   always @(posedge ref_clk) begin
      if (mc_req === 1'b1 && mc_op !== MC_LOAD) begin
         if (req_q.size() == 0) begin
            miscompares++;
            $display("Error mc_req expected 0 seen 1");
         end else begin
            er = req_q.pop_front();
            `CHK("mc_op", er.o, mc_op)
            if (er.o == MC_PROGRAM || er.o == MC_ERASE_SECTOR) begin
               `CHK("mc_words", er.n, mc_words)
               `CHK("mc_addr", er.a, mc_addr)
               `CHK("mc_wdata first", er.w[0], mc_wdata[0])
               if (er.n != 3'h0) `CHK("mc_wdata last", er.w[er.n - 3'h1], mc_wdata[er.n - 3'h1])
            end
         end
      end
      if (rise_d) `CHK("cmd_irq", irq_en, cmd_irq)
      rise_d = command_complete_flag === 1'b1 && !prev_flag;
      if (rise_d && done_q.size() != 0) begin
         en = done_q.pop_front();
         `CHK("error flags", en[3:2], {access_error_flag, protection_violation_flag})
         if (en[3:2] == 2'b00) `CHK("verify bits", en[1:0], {verify_status_upper, verify_status_lower})
      end
      prev_flag = command_complete_flag === 1'b1;
   end
   initial begin
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      wait_flag();
      `CHK("block_cfg", 16'h5a3c, block_cfg)
      `CHK("option and security", 16'hff02, {flash_option_reg, flash_security_reg})
      `CHK("program protection", 8'h00, program_memory_protection_reg)
      `CHK("stall and read", 2'b01, {cpu_stall, flash_read_en})
      `CHK("secured and debug", 2'b01, {secured, debug_cmds_en})
      for (int i = 2; i <= 5; i++) launch(i[2:0], EB + 18'(i * 16), 4'h0);
      foreach (bad_idx[j]) launch(bad_idx[j], EB + 18'h00100, 4'h8);
      launch(3'h2, EB + 18'h00101, 4'h8);
      launch(3'h4, EB + EN - 18'h00004, 4'h8);
      launch(3'h2, EB + EN - 18'h00002, 4'h0);
      launch(3'h2, 18'h08000, 4'h8);
      err_in = 1'b1;
      launch(3'h3, EB + 18'h00200, 4'h2);
      uncorr_in = 1'b1;
      launch(3'h2, EB + 18'h00210, 4'h3);
      {err_in, uncorr_in} = 2'b00;
      spec = 1'b1;
      pdata = 8'h81;
      repeat (6) @(negedge ref_clk);
      ewr = 1'b1;
      @(negedge ref_clk);
      ewr = 1'b0;
      repeat (2) @(negedge ref_clk);
      `CHK("eeprom_protection_reg", 8'h81, eeprom_protection_reg)
      launch(3'h2, EB + 18'h00020, 4'h4);
      launch(3'h2, EB + 18'h00300, 4'h0);
      code = CMD_ERASE_EE_SECTOR;
      launch(3'h1, EB + 18'h00306, 4'h0);
      launch(3'h1, EB + 18'h00010, 4'h4);
      code = CMD_PROGRAM_EEPROM;
      // Second reset with a double-bit fault on every load
      uncorr_in = 1'b1;
      rstn = 1'b0;
      repeat (3) @(negedge ref_clk);
      rstn = 1'b1;
      // Early enough that the protection load cannot have finished
      repeat (8) @(negedge ref_clk);
      `CHK("flag and stall during init", 2'b01, {command_complete_flag, cpu_stall})
      wait_flag();
      `CHK("verify bits after init", 2'b11, {verify_status_upper, verify_status_lower})
      `CHK("defaults", {1'b1, 16'hc0c0}, {secured, program_memory_protection_reg, eeprom_protection_reg})
      uncorr_in = 1'b0;
      // Secured part in special mode; protection is also still on
      launch(3'h2, EB + 18'h00400, 4'hc);
      pdata = 8'h00;
      {fwr, ewr} = 2'b11;
      @(negedge ref_clk);
      {fwr, ewr} = 2'b00;
      `CHK("protection cleared", 16'h0000, {program_memory_protection_reg, eeprom_protection_reg})
      code = CMD_UNSECURE;
      launch(3'h0, 18'h00000, 4'h0);
      `CHK("unsecured", 2'b01, {secured, debug_cmds_en})
      code = CMD_ERASE_VERIFY_ALL;
      launch(3'h0, 18'h00000, 4'h0);
      wrap_up();
   end
endmodule
`default_nettype wire

/* File: epcs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module epcs_top
   import epcs_pkg::*;
#(
   parameter logic [17:0] EE_BASE = 18'h00400,
   parameter logic [17:0] EE_BYTES = 18'h00c00,
   parameter logic [17:0] PF_BASE = 18'h08000,
   parameter logic [17:0] SECTOR_BYTES = 18'h00004
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Command launch
   input wire logic cmd_launch,
   input wire logic [7:0] cmd_code,
   input wire logic [2:0] command_param_index,
   input wire logic [17:0] cmd_addr,
   input wire logic [3:0][15:0] command_param_object,
   input wire logic err_flags_clr,
   // Configuration
   input wire logic command_complete_irq_enable,
   input wire logic special_mode_pin,
   input wire logic program_memory_protection_reg_wr,
   input wire logic eeprom_protection_reg_wr,
   input wire logic [7:0] prot_wdata,
   // Status
   output logic command_complete_flag,
   output logic access_error_flag,
   output logic protection_violation_flag,
   output logic verify_status_upper,
   output logic verify_status_lower,
   output logic cmd_irq,
   output logic cpu_stall,
   output logic flash_read_en,
   output logic secured,
   output logic debug_cmds_en,
   output logic [7:0] program_memory_protection_reg,
   output logic [7:0] eeprom_protection_reg,
   output logic [7:0] flash_option_reg,
   output logic [7:0] flash_security_reg,
   output logic [15:0] block_cfg,
   // Memory controller
   output logic mc_req,
   output epcs_mc_op_t mc_op,
   output logic [17:0] mc_addr,
   output logic [2:0] mc_words,
   output logic [3:0][15:0] mc_wdata,
   input wire logic mc_done,
   input wire logic mc_err,
   input wire logic mc_uncorr,
   input wire logic [15:0] mc_rdata
);
   if (EE_BYTES == 18'h0 || EE_BYTES[0] || (SECTOR_BYTES & (SECTOR_BYTES - 18'h1)) != 18'h0) begin : g_bad_cfg
      $error("epcs_top: EEPROM size must be even and sector size a power of two");
   end

   localparam logic [17:0] EE_LAST = 18'(EE_BASE + EE_BYTES - 18'h1);

   logic [1:0] rst_sync_ff;
   logic rst_n;
   logic [2:0] spm_sync_ff;
   logic special_mode_ff;
   epcs_state_t state_ff;
   logic [1:0] init_step_ff;
   logic init_fail_ff;
   logic [7:0] cmd_ff;
   logic mc_req_ff, command_complete_flag_ff, access_error_flag_ff, protection_violation_flag_ff, vs_upper_ff, vs_lower_ff, irq_ff;
   logic stall_ff, read_en_ff, secured_ff, debug_en_ff;
   epcs_mc_op_t mc_op_ff;
   logic [17:0] mc_addr_ff;
   logic [2:0] mc_words_ff;
   logic [3:0][15:0] mc_wdata_ff;
   logic [7:0] program_memory_protection_reg_ff, eeprom_protection_reg_ff, flash_option_reg_ff, flash_security_reg_ff;
   logic [15:0] cfg_ff;
   logic chk_acc, chk_pv, launch_try, launch_ok, launch_bad, init_done_evt, init_bad, verify_pass;
   logic [2:0] n_words;
   logic [17:0] grp_last, launch_addr;
   epcs_mc_op_t op_sel;

   function automatic logic in_ee(input logic [17:0] a);
      return a >= EE_BASE && a <= EE_LAST;
   endfunction

   // Offset counts from the protected edge of the region
   function automatic logic prot_hit(input logic [7:0] pr, input logic [17:0] off);
      logic [17:0] span;
      span = 18'({12'h000, pr[5:0]} << PROT_UNIT_SHIFT);
      return pr[PROT_EN_BIT] && (pr[PROT_ALL_BIT] || off < span);
   endfunction

   function automatic logic cmd_allowed(input logic [7:0] code, input logic spec, input logic sec);
      logic ok;
      ok = !sec;
      if (sec && spec) begin
         ok = code == CMD_ERASE_VERIFY_ALL || code == CMD_ERASE_ALL || code == CMD_UNSECURE;
      end
      return ok;
   endfunction

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // Mode pin taken only once two late stages agree
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         spm_sync_ff <= 3'h0;
         special_mode_ff <= 1'b0;
      end else begin
         spm_sync_ff <= {spm_sync_ff[1:0], special_mode_pin};
         if (spm_sync_ff[1] == spm_sync_ff[2]) begin
            special_mode_ff <= spm_sync_ff[2];
         end
      end
   end

   // Launch checks, evaluated on the values held at launch
   always_comb begin
      n_words = 3'(command_param_index - IDX_ADDR_LO);
      grp_last = 18'(cmd_addr + 18'({n_words, 1'b0}) - 18'h1);
      launch_addr = cmd_addr;
      op_sel = MC_NONE;
      chk_pv = 1'b0;
      chk_acc = !cmd_allowed(cmd_code, special_mode_ff, secured_ff);
      unique case (cmd_code)
         CMD_PROGRAM_EEPROM: begin
            op_sel = MC_PROGRAM;
            chk_acc = chk_acc || command_param_index < IDX_FIRST_WORD || command_param_index > IDX_LAST_WORD;
            chk_acc = chk_acc || !in_ee(cmd_addr) || cmd_addr[0] || grp_last > EE_LAST;
            chk_pv = prot_hit(eeprom_protection_reg_ff, 18'(cmd_addr - EE_BASE));
         end
         CMD_ERASE_EE_SECTOR: begin
            op_sel = MC_ERASE_SECTOR;
            launch_addr = cmd_addr & ~(SECTOR_BYTES - 18'h1);
            chk_acc = chk_acc || command_param_index != IDX_ADDR_LO || !in_ee(cmd_addr) || cmd_addr[0];
            chk_pv = prot_hit(eeprom_protection_reg_ff, 18'(launch_addr - EE_BASE));
         end
         CMD_PROGRAM_PFLASH: begin
            op_sel = MC_PROGRAM;
            chk_acc = chk_acc || command_param_index != IDX_LAST_WORD || cmd_addr < PF_BASE || cmd_addr[2:0] != 3'h0;
            // key field open to an unsecured user
            chk_pv = prot_hit(program_memory_protection_reg_ff, 18'(ADDR_TOP - cmd_addr)) &&
                     !(!secured_ff && cmd_addr >= KEY_FIRST && cmd_addr <= KEY_LAST);
         end
         CMD_ERASE_VERIFY_ALL: begin
            op_sel = MC_ERASE_VERIFY_ALL;
            chk_acc = chk_acc || command_param_index != IDX_NONE;
         end
         CMD_ERASE_ALL, CMD_UNSECURE: begin
            op_sel = MC_ERASE_ALL;
            chk_acc = chk_acc || command_param_index != IDX_NONE;
            chk_pv = program_memory_protection_reg_ff[PROT_EN_BIT] || eeprom_protection_reg_ff[PROT_EN_BIT];
         end
         default: chk_acc = 1'b1;
      endcase
   end

   // Pending error flags block further launches until cleared
   assign launch_try = cmd_launch && state_ff == ST_IDLE && command_complete_flag_ff && !access_error_flag_ff && !protection_violation_flag_ff;
   assign launch_ok = launch_try && !chk_acc && !chk_pv;
   assign launch_bad = launch_try && !launch_ok;
   assign init_done_evt = state_ff == ST_INIT_WAIT && mc_done;
   assign init_bad = init_fail_ff || mc_err || mc_uncorr;
   assign verify_pass = mc_done && mc_op_ff == MC_ERASE_VERIFY_ALL && !mc_err && !mc_uncorr &&
                        (state_ff == ST_RUN || state_ff == ST_UNSEC_VERIFY);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_INIT;
         init_step_ff <= INIT_STEP_CFG;
         init_fail_ff <= 1'b0;
         cmd_ff <= 8'h00;
         mc_req_ff <= 1'b0;
         mc_op_ff <= MC_NONE;
         mc_addr_ff <= 18'h00000;
         mc_words_ff <= 3'h0;
         mc_wdata_ff <= '0;
      end else begin
         mc_req_ff <= 1'b0;
         unique case (state_ff)
            ST_INIT: begin
               mc_req_ff <= 1'b1;
               mc_op_ff <= MC_LOAD;
               mc_addr_ff <= 18'(init_step_ff);
               state_ff <= ST_INIT_WAIT;
            end
            ST_INIT_WAIT: begin
               if (mc_done) begin
                  init_fail_ff <= init_bad;
                  if (init_step_ff == INIT_STEP_OPTSEC) begin
                     state_ff <= ST_FINISH;
                  end else begin
                     init_step_ff <= 2'(init_step_ff + 2'h1);
                     state_ff <= ST_INIT;
                  end
               end
            end
            ST_IDLE: begin
               // only clean launches reach the array
               if (launch_ok) begin
                  cmd_ff <= cmd_code;
                  mc_req_ff <= 1'b1;
                  mc_op_ff <= op_sel;
                  mc_addr_ff <= launch_addr;
                  mc_words_ff <= n_words;
                  mc_wdata_ff <= command_param_object;
                  state_ff <= ST_RUN;
               end else if (launch_bad) begin
                  state_ff <= ST_FINISH;
               end
            end
            ST_RUN: begin
               if (mc_done) begin
                  // unsecure command verifies its own erase
                  if (cmd_ff == CMD_UNSECURE && !mc_err && !mc_uncorr) begin
                     mc_req_ff <= 1'b1;
                     mc_op_ff <= MC_ERASE_VERIFY_ALL;
                     mc_addr_ff <= 18'h00000;
                     state_ff <= ST_UNSEC_VERIFY;
                  end else begin
                     state_ff <= ST_FINISH;
                  end
               end
            end
            ST_UNSEC_VERIFY: begin
               if (mc_done) begin
                  state_ff <= ST_FINISH;
               end
            end
            ST_FINISH: state_ff <= ST_IDLE;
         endcase
      end
   end

   // Status flags; a set in the clearing cycle wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         command_complete_flag_ff <= 1'b0;
         access_error_flag_ff <= 1'b0;
         protection_violation_flag_ff <= 1'b0;
         vs_upper_ff <= 1'b0;
         vs_lower_ff <= 1'b0;
      end else begin
         // cleared at launch, set on finish
         if (launch_try) begin
            command_complete_flag_ff <= 1'b0;
         end else if (state_ff == ST_FINISH) begin
            command_complete_flag_ff <= 1'b1;
         end
         if (launch_try && chk_acc) begin
            access_error_flag_ff <= 1'b1;
         end else if (err_flags_clr) begin
            access_error_flag_ff <= 1'b0;
         end
         if (launch_try && chk_pv) begin
            protection_violation_flag_ff <= 1'b1;
         end else if (err_flags_clr) begin
            protection_violation_flag_ff <= 1'b0;
         end
         if (launch_try) begin
            vs_upper_ff <= 1'b0;
            vs_lower_ff <= 1'b0;
         end else if (init_done_evt) begin
            if (mc_uncorr) begin
               vs_upper_ff <= 1'b1;
               vs_lower_ff <= 1'b1;
            end
         end else if (mc_done && (state_ff == ST_RUN || state_ff == ST_UNSEC_VERIFY)) begin
            // verify outcome; a blank-check miss sets both
            vs_upper_ff <= vs_upper_ff || mc_err || mc_uncorr;
            vs_lower_ff <= vs_lower_ff || mc_uncorr || (mc_op_ff == MC_ERASE_VERIFY_ALL && mc_err);
         end
      end
   end

   // Loaded configuration, protection and security
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= CFG_DEFAULT;
         program_memory_protection_reg_ff <= PROT_DEFAULT;
         eeprom_protection_reg_ff <= PROT_DEFAULT;
         flash_option_reg_ff <= FLASH_OPTION_REG_DEFAULT;
         flash_security_reg_ff <= FLASH_SECURITY_REG_DEFAULT;
         secured_ff <= 1'b1;
         debug_en_ff <= 1'b0;
      end else if (init_done_evt) begin
         unique case (init_step_ff)
            INIT_STEP_CFG: cfg_ff <= mc_rdata;
            INIT_STEP_PROGRAM_MEMORY_PROTECTION_REG: program_memory_protection_reg_ff <= mc_rdata[7:0];
            INIT_STEP_EEPROM_PROTECTION_REG: eeprom_protection_reg_ff <= mc_rdata[7:0];
            INIT_STEP_OPTSEC: begin
               // any load fault leaves everything locked
               if (init_bad) begin
                  cfg_ff <= CFG_DEFAULT;
                  program_memory_protection_reg_ff <= PROT_DEFAULT;
                  eeprom_protection_reg_ff <= PROT_DEFAULT;
                  flash_option_reg_ff <= FLASH_OPTION_REG_DEFAULT;
                  flash_security_reg_ff <= FLASH_SECURITY_REG_DEFAULT;
                  secured_ff <= 1'b1;
                  debug_en_ff <= 1'b0;
               end else begin
                  flash_option_reg_ff <= mc_rdata[15:8];
                  flash_security_reg_ff <= mc_rdata[7:0];
                  secured_ff <= mc_rdata[1:0] != SEC_UNSECURED;
                  debug_en_ff <= mc_rdata[1:0] == SEC_UNSECURED;
               end
            end
         endcase
      end else if (verify_pass) begin
         secured_ff <= 1'b0;
         debug_en_ff <= 1'b1;
      end else if (state_ff == ST_IDLE && special_mode_ff) begin
         // host lifts protection in special mode
         if (program_memory_protection_reg_wr) begin
            program_memory_protection_reg_ff <= prot_wdata;
         end
         if (eeprom_protection_reg_wr) begin
            eeprom_protection_reg_ff <= prot_wdata;
         end
      end
   end

   // CPU hold ends once program memory protection is loaded
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stall_ff <= 1'b1;
         read_en_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         if (init_done_evt && init_step_ff == INIT_HOLD_LAST) begin
            stall_ff <= 1'b0;
            read_en_ff <= 1'b1;
         end
         irq_ff <= command_complete_flag_ff && command_complete_irq_enable;
      end
   end

   assign command_complete_flag = command_complete_flag_ff;
   assign access_error_flag = access_error_flag_ff;
   assign protection_violation_flag = protection_violation_flag_ff;
   assign verify_status_upper = vs_upper_ff;
   assign verify_status_lower = vs_lower_ff;
   assign cmd_irq = irq_ff;
   assign cpu_stall = stall_ff;
   assign flash_read_en = read_en_ff;
   assign secured = secured_ff;
   assign debug_cmds_en = debug_en_ff;
   assign program_memory_protection_reg = program_memory_protection_reg_ff;
   assign eeprom_protection_reg = eeprom_protection_reg_ff;
   assign flash_option_reg = flash_option_reg_ff;
   assign flash_security_reg = flash_security_reg_ff;
   assign block_cfg = cfg_ff;
   assign mc_req = mc_req_ff;
   assign mc_op = mc_op_ff;
   assign mc_addr = mc_addr_ff;
   assign mc_words = mc_words_ff;
   assign mc_wdata = mc_wdata_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_idx_low;
      launch_try && cmd_code == CMD_PROGRAM_EEPROM && command_param_index < IDX_FIRST_WORD |=> access_error_flag_ff;
   endproperty
   a_idx_low: assert property (p_idx_low) else $error("index below two not flagged");
   property p_idx_high;
      launch_try && cmd_code == CMD_PROGRAM_EEPROM && command_param_index > IDX_LAST_WORD |=> access_error_flag_ff && !mc_req_ff;
   endproperty
   a_idx_high: assert property (p_idx_high) else $error("index above five not flagged");
   property p_misalign;
      launch_try && cmd_code == CMD_PROGRAM_EEPROM && cmd_addr[0] |=> access_error_flag_ff;
   endproperty
   a_misalign: assert property (p_misalign) else $error("odd address not flagged");
   property p_reject;
      launch_bad |=> !mc_req_ff && !command_complete_flag_ff ##1 command_complete_flag_ff;
   endproperty
   a_reject: assert property (p_reject) else $error("rejected launch reached array or stalled");
   property p_words;
      launch_ok && cmd_code == CMD_PROGRAM_EEPROM |=> mc_req_ff && mc_words_ff == $past(command_param_index) - 3'h1;
   endproperty
   a_words: assert property (p_words) else $error("word count not taken from index");
   property p_done;
      state_ff == ST_RUN && mc_done && cmd_ff != CMD_UNSECURE |=> !command_complete_flag_ff ##1 command_complete_flag_ff;
   endproperty
   a_done: assert property (p_done) else $error("completion flag not set after operation");
   property p_init_low;
      state_ff == ST_INIT || state_ff == ST_INIT_WAIT |-> !command_complete_flag_ff;
   endproperty
   a_init_low: assert property (p_init_low) else $error("completion flag high during init");
   property p_init_dbf;
      init_done_evt && mc_uncorr |=> vs_upper_ff && vs_lower_ff;
   endproperty
   a_init_dbf: assert property (p_init_dbf) else $error("init double fault not reported");
   property p_fallback;
      init_done_evt && init_step_ff == INIT_STEP_OPTSEC && init_bad |=> secured_ff && eeprom_protection_reg_ff == PROT_DEFAULT;
   endproperty
   a_fallback: assert property (p_fallback) else $error("init fault left part open");
   property p_irq;
      $rose(command_complete_flag_ff) && command_complete_irq_enable |=> cmd_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("completion interrupt missing");
   property p_stall;
      state_ff == ST_IDLE |-> !cpu_stall && flash_read_en;
   endproperty
   a_stall: assert property (p_stall) else $error("cpu still held after init");
endmodule
`default_nettype wire
